/* csq_pkg.sv */
// Purpose: Shared constants and types for the core supply mode sequencer
// Assumes: 50 MHz controller clock, synchronous active-high reset
// Notes: Times are kept in their own units; cycle counts derive from them
package csq_pkg;

  localparam int CLK_MHZ = 50;
  // Startup delay from clock-go falling to regulation-good release
  localparam int PGOOD_DELAY_US = 5000;
  localparam int PGOOD_DELAY_CYC = PGOOD_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // Slew divisor for soft-start and soft-shutdown
  localparam int SOFT_SLEW_DIV = 8;
  localparam int SLEW_W = 4;
  localparam logic [SLEW_W-1:0] SLEW_FULL = 4'h1;
  localparam logic [SLEW_W-1:0] SLEW_SOFT = 4'h8;

  localparam int CODE_W = 7;
  localparam logic [CODE_W-1:0] CODE_RESET = 7'h00;

  // Operating modes
  typedef enum logic [2:0] {
    CSQ_SKIP_VLOW,
    CSQ_SKIP_LOW,
    CSQ_PWM_ONE,
    CSQ_PWM_MAX_ONE,
    CSQ_PWM_MAX_TWO
  } csq_mode_t;

  // Sequencer states
  typedef enum logic [2:0] {
    CSQ_OFF,
    CSQ_SOFT_START,
    CSQ_BOOT,
    CSQ_TO_CODE,
    CSQ_RUN,
    CSQ_SOFT_STOP
  } csq_state_t;

endpackage

/* csq_sequencer.sv */
// Purpose: Mode decode and status sequencing for a two-phase core supply
// Assumes: Analog comparator results arrive as asynchronous pin levels
// Notes: Open-drain outputs use low-active enables; low enable drives 0
`timescale 1ns/1ps

// Behaviour
// - Clock-go goes low while feedback is within regulation.
// - Clock-go held low during any voltage-code transition.
// - Outside startup, clock-go is the inverse of regulation-good.
// - With deep-sleep high, ignore the upper threshold for clock-go.
// - After transitions, regulation-good releases when feedback is in regulation.
// - At startup, regulation-good stays low through boot and 5 ms after clock-go.
// - Regulation-good is driven low in shutdown.
// - Regulation-good released while the slew controller ramps.
// - With deep-sleep high, upper comparator cannot pull regulation-good low.
// - Deep-sleep selects one-phase skip; else power-state 0 selects one-phase PWM.
// - Deep-sleep low, power-state high: maximum PWM, phases per strap.
// - Force full-phase PWM in startup, boot, boot transition and shutdown.
// - Thermal alarm pulls low when sense is below threshold; released in shutdown (code releases it only when off and still pulls low during soft-shutdown).
// - Full slew rate for skip-mode entry, exit and boot-to-code.
// - Soft-start and soft-shutdown ramp at one eighth slew rate.
// - Clocked code steps followed at stepping rate, capped at programmed slew.
// - Integrator disabled in skip mode while output is above target.
module csq_sequencer
  import csq_pkg::*;
#(
  // Boot delay in cycles; a bench may shorten it to keep runs brief
  parameter int PG_DELAY_CYC = PGOOD_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Platform control inputs (asynchronous)
  input wire logic enable,
  input wire logic deep_sleep_request,
  input wire logic power_state_indicator,
  input wire logic [CODE_W-1:0] voltage_code,
  input wire logic [CODE_W-1:0] boot_code,
  // Analog comparator results (asynchronous)
  input wire logic feedback_sense_below_upper,
  input wire logic feedback_sense_above_lower,
  input wire logic thermistor_sense_in_low,
  input wire logic phase2_sense_positive_high,
  // Slew engine status
  input wire logic slew_at_target,
  // Status pins
  output logic clock_go_out_n,
  output logic output_regulation_good_oe_n,
  output logic output_regulation_good_o,
  output logic thermal_alarm_out_n_oe_n,
  output logic thermal_alarm_out_n_o,
  // Regulator control
  output csq_mode_t op_mode,
  output logic [CODE_W-1:0] target_code,
  output logic [SLEW_W-1:0] slew_divisor,
  output logic slew_active,
  output logic integrator_enable,
  output logic phase2_enable
);

  localparam int SYNC_W = 2 * CODE_W + 7;

  typedef struct packed {
    csq_state_t state;
    csq_mode_t mode;
    logic one_phase;
    logic [CODE_W-1:0] target;
    logic [CODE_W-1:0] last_code;
    logic [SLEW_W-1:0] slew_div;
    logic ramping;
    logic [CNT_W-1:0] pg_cnt;
    logic pg_done;
    logic clk_go_n;
    logic pgood_rel;
    logic hot;
    logic integ_en;
  } csq_st_t;

  csq_st_t st;
  csq_st_t next_st;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic s_en;
  logic s_dsr;
  logic s_psi;
  logic [CODE_W-1:0] s_code;
  logic [CODE_W-1:0] s_boot;
  logic s_below_up;
  logic s_above_lo;
  logic s_therm_low;
  logic s_ph2_high;
  logic in_reg;
  logic skip_now;
  csq_mode_t decoded;

  // All pin-level inputs pass a two-flop synchroniser
  assign sync_in = {enable, deep_sleep_request, power_state_indicator,
                    voltage_code, boot_code, feedback_sense_below_upper,
                    feedback_sense_above_lower, thermistor_sense_in_low,
                    phase2_sense_positive_high};

  csq_sync2 #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(sync_in),
    .q(sync_out)
  );

  assign {s_en, s_dsr, s_psi, s_code, s_boot, s_below_up, s_above_lo,
          s_therm_low, s_ph2_high} = sync_out;

  // Upper threshold blanked while the deep-sleep request is high
  assign in_reg = s_above_lo & (s_below_up | s_dsr);
  assign skip_now = (st.mode == CSQ_SKIP_VLOW) |
                    (st.mode == CSQ_SKIP_LOW);

  // Mode truth table, strap picks phase count for maximum power
  always_comb begin
    if (s_dsr) begin
      decoded = s_psi ? CSQ_SKIP_LOW : CSQ_SKIP_VLOW;
    end else if (!s_psi) begin
      decoded = CSQ_PWM_ONE;
    end else if (st.one_phase) begin
      decoded = CSQ_PWM_MAX_ONE;
    end else begin
      decoded = CSQ_PWM_MAX_TWO;
    end
  end

  // Sequencer next state
  always_comb begin
    logic dec_skip;
    dec_skip = 1'b0;
    next_st = st;
    next_st.hot = s_therm_low;
    dec_skip = (decoded == CSQ_SKIP_VLOW) | (decoded == CSQ_SKIP_LOW);
    case (st.state)
      CSQ_OFF: begin
        // Strap is sampled every cycle while the supply is off, then held
        next_st.one_phase = s_ph2_high;
        next_st.mode = CSQ_PWM_MAX_TWO;
        next_st.target = CODE_RESET;
        next_st.ramping = 1'b0;
        next_st.pg_cnt = '0;
        next_st.pg_done = 1'b0;
        next_st.clk_go_n = 1'b1;
        next_st.pgood_rel = 1'b0;
        if (s_en) begin
          next_st.state = CSQ_SOFT_START;
          next_st.target = s_boot;
          next_st.slew_div = SLEW_SOFT;
          next_st.ramping = 1'b1;
        end
      end
      CSQ_SOFT_START: begin
        next_st.mode = CSQ_PWM_MAX_TWO;
        if (slew_at_target) begin
          next_st.ramping = 1'b0;
          next_st.state = CSQ_BOOT;
        end
      end
      CSQ_BOOT: begin
        next_st.mode = CSQ_PWM_MAX_TWO;
        next_st.pgood_rel = 1'b0;
        next_st.clk_go_n = !in_reg;
        if (!st.clk_go_n) begin
          if (st.pg_cnt == CNT_W'(PG_DELAY_CYC - 1)) begin
            next_st.pg_done = 1'b1;
          end else begin
            next_st.pg_cnt = st.pg_cnt + 1'b1;
          end
        end
        if (st.pg_done) begin
          // Boot to code move uses full slew
          next_st.state = CSQ_TO_CODE;
          next_st.target = s_code;
          next_st.last_code = s_code;
          next_st.slew_div = SLEW_FULL;
          next_st.ramping = 1'b1;
          // Ramp starts now, so good is released and clock-go held low
          next_st.pgood_rel = 1'b1;
          next_st.clk_go_n = 1'b0;
        end
      end
      CSQ_TO_CODE: begin
        next_st.mode = CSQ_PWM_MAX_TWO;
        next_st.pgood_rel = 1'b1;
        next_st.clk_go_n = 1'b0;
        if (slew_at_target) begin
          next_st.ramping = 1'b0;
          next_st.state = CSQ_RUN;
          next_st.mode = decoded;
        end
      end
      CSQ_RUN: begin
        next_st.mode = decoded;
        if (s_code != st.last_code) begin
          // Clocked code steps: each step re-targets, slew caps the rate
          next_st.last_code = s_code;
          next_st.target = s_code;
          next_st.slew_div = SLEW_FULL;
          next_st.ramping = 1'b1;
        end else if (dec_skip != skip_now) begin
          next_st.slew_div = SLEW_FULL;
          next_st.ramping = 1'b1;
        end else if (slew_at_target) begin
          next_st.ramping = 1'b0;
        end
        // Released while ramping, else follows the window
        next_st.pgood_rel = next_st.ramping | in_reg;
        next_st.clk_go_n = next_st.ramping ? 1'b0
                           : !next_st.pgood_rel;
      end
      CSQ_SOFT_STOP: begin
        next_st.mode = CSQ_PWM_MAX_TWO;
        next_st.pgood_rel = 1'b0;
        next_st.clk_go_n = 1'b1;
        if (slew_at_target) begin
          next_st.ramping = 1'b0;
          next_st.state = CSQ_OFF;
        end
      end
      default: begin
        next_st.state = CSQ_OFF;
      end
    endcase
    // Shutdown request wins from any active state
    if (!s_en && st.state != CSQ_OFF && st.state != CSQ_SOFT_STOP) begin
      next_st.state = CSQ_SOFT_STOP;
      next_st.target = CODE_RESET;
      next_st.slew_div = SLEW_SOFT;
      next_st.ramping = 1'b1;
      next_st.pgood_rel = 1'b0;
      next_st.clk_go_n = 1'b1;
      next_st.mode = CSQ_PWM_MAX_TWO;
    end
    // Integrator off in skip with output above target
    next_st.integ_en = !(dec_skip && !s_below_up &&
                         next_st.state == CSQ_RUN);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{state: CSQ_OFF, mode: CSQ_PWM_MAX_TWO, one_phase: 1'b0,
              target: CODE_RESET, last_code: CODE_RESET,
              slew_div: SLEW_FULL, ramping: 1'b0, pg_cnt: '0,
              pg_done: 1'b0, clk_go_n: 1'b1, pgood_rel: 1'b0,
              hot: 1'b0, integ_en: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // Outputs; open-drain enables low means pin driven low
  assign clock_go_out_n = st.clk_go_n;
  assign output_regulation_good_o = 1'b0;
  assign output_regulation_good_oe_n = st.pgood_rel;
  assign thermal_alarm_out_n_o = 1'b0;
  assign thermal_alarm_out_n_oe_n =
    !(st.hot && st.state != CSQ_OFF);
  assign op_mode = st.mode;
  assign target_code = st.target;
  assign slew_divisor = st.slew_div;
  assign slew_active = st.ramping;
  assign integrator_enable = st.integ_en;
  assign phase2_enable = (st.mode == CSQ_PWM_MAX_TWO);

  // Checks
  a_clkgo_in_ramp: assert property (@(posedge clk) disable iff (rst)
    (st.ramping && (st.state == CSQ_RUN || st.state == CSQ_TO_CODE))
      |-> !clock_go_out_n)
    else $error("clock-go high during ramp");
  a_clkgo_inverse: assert property (@(posedge clk) disable iff (rst)
    (st.state != CSQ_BOOT) |->
      (clock_go_out_n != output_regulation_good_oe_n))
    else $error("clock-go not inverse of good");
  a_pgood_off_low: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_OFF || st.state == CSQ_SOFT_STOP) |->
      !output_regulation_good_oe_n)
    else $error("good released in shutdown");
  a_pgood_boot_low: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_BOOT) |-> !output_regulation_good_oe_n)
    else $error("good released in boot");
  a_pgood_release: assert property (@(posedge clk) disable iff (rst)
    $rose(output_regulation_good_oe_n) |->
      (st.state == CSQ_RUN || st.state == CSQ_TO_CODE))
    else $error("good released in startup or shutdown");
  a_ramp_release: assert property (@(posedge clk) disable iff (rst)
    (st.ramping && (st.state == CSQ_RUN || st.state == CSQ_TO_CODE))
      |-> output_regulation_good_oe_n)
    else $error("good low while ramping");
  a_force_full: assert property (@(posedge clk) disable iff (rst)
    (st.state != CSQ_RUN) |-> (op_mode == CSQ_PWM_MAX_TWO))
    else $error("mode not forced in sequence");
  a_skip_decode: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_RUN && $past(st.state) == CSQ_RUN && $past(s_dsr))
      |-> skip_now)
    else $error("deep sleep did not select skip");
  a_strap_phase: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_RUN && st.one_phase) |->
      (op_mode != CSQ_PWM_MAX_TWO && !phase2_enable))
    else $error("two phases with one-phase strap");
  a_soft_slew: assert property (@(posedge clk) disable iff (rst)
    $rose(st.state == CSQ_SOFT_STOP) |-> (slew_divisor == SLEW_SOFT))
    else $error("soft stop without eighth slew");
  a_start_slew: assert property (@(posedge clk) disable iff (rst)
    $rose(st.state == CSQ_SOFT_START) |-> (slew_divisor == SLEW_SOFT))
    else $error("soft start without eighth slew");
  a_boot_full_slew: assert property (@(posedge clk) disable iff (rst)
    $rose(st.state == CSQ_TO_CODE) |-> (slew_divisor == SLEW_FULL))
    else $error("boot to code without full slew");
  a_hot_off: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_OFF) |-> thermal_alarm_out_n_oe_n)
    else $error("thermal alarm driven in shutdown");
  a_hot_pull: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_RUN && st.hot) |-> !thermal_alarm_out_n_oe_n)
    else $error("thermal alarm not driven when hot");
  a_integ_skip: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_RUN && skip_now && $past(!s_below_up) && !st.ramping
     && $past(st.state) == CSQ_RUN && st.mode == $past(st.mode))
      |-> !integrator_enable)
    else $error("integrator on in skip above target");
  a_integ_pwm: assert property (@(posedge clk) disable iff (rst)
    (st.state == CSQ_RUN && !skip_now) |-> integrator_enable)
    else $error("integrator off outside skip");
  a_boot_delay: assert property (@(posedge clk) disable iff (rst)
    $rose(st.state == CSQ_TO_CODE) |->
      (st.pg_cnt == CNT_W'(PG_DELAY_CYC - 1)))
    else $error("boot left before delay");

  c_start: cover property (@(posedge clk) disable iff (rst)
    $rose(st.state == CSQ_BOOT));
  c_run: cover property (@(posedge clk) disable iff (rst)
    $rose(st.state == CSQ_RUN));
  c_skip: cover property (@(posedge clk) disable iff (rst)
    st.state == CSQ_RUN && skip_now);
  c_stop: cover property (@(posedge clk) disable iff (rst)
    $rose(st.state == CSQ_SOFT_STOP));
  c_one_phase: cover property (@(posedge clk) disable iff (rst)
    st.state == CSQ_RUN && op_mode == CSQ_PWM_MAX_ONE);

endmodule

/* csq_slew_model.sv */
// Purpose: Behavioural slew engine and feedback window facing the sequencer
// Assumes: One code step per STEP_CYC times the divisor, same clock
// Notes: Window faults are commanded by the bench through over and under
`timescale 1ns/1ps
module csq_slew_model
  import csq_pkg::*;
#(
  parameter int STEP_CYC = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the sequencer
  input wire logic [CODE_W-1:0] target_code,
  input wire logic [SLEW_W-1:0] slew_divisor,
  // Commanded window faults
  input wire logic over,
  input wire logic under,
  // To the sequencer
  output logic slew_at_target,
  output logic below_upper,
  output logic above_lower
);
  logic [CODE_W-1:0] level;
  logic [15:0] tick;
  // Step interval scales with the divisor, so soft ramps run 8x slower
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= CODE_RESET;
      tick <= 16'h0000;
    end else if (level == target_code) begin
      tick <= 16'h0000;
    end else if (tick + 16'h0001 >= 16'(slew_divisor) * 16'(STEP_CYC)) begin
      tick <= 16'h0000;
      level <= (level < target_code) ? level + 7'h01 : level - 7'h01;
    end else begin
      tick <= tick + 16'h0001;
    end
  end
  // Window tracks the modelled level; a commanded fault overrides it
  assign slew_at_target = (level == target_code);
  assign below_upper = !over && !(level > target_code);
  assign above_lower = !under && !(level < target_code);
endmodule

/* csq_sync2.sv */
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels
// Assumes: Inputs are quasi-static levels from pins
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module csq_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } csq_sync_st_t;

  csq_sync_st_t st;
  csq_sync_st_t next_st;

  // Shift one stage per clock
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // Register stage pair
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the core supply mode sequencer
// Assumes: Inputs change on the falling edge; outputs are read there too
// Notes: Boot delay is shortened through a parameter to keep the run brief
`timescale 1ns/1ps
module tb_top
  import csq_pkg::*;
;
  logic clk, rst, enable, deep_sleep_request, power_state_indicator;
  logic [CODE_W-1:0] voltage_code, boot_code;
  logic over, under, thermistor_sense_in_low, strap;
  logic below_upper, above_lower, slew_at_target;
  logic clock_go_out_n, good_oe_n, good_o, hot_oe_n, hot_o;
  csq_mode_t op_mode;
  logic [CODE_W-1:0] target_code;
  logic [SLEW_W-1:0] slew_divisor;
  logic slew_active, integrator_enable, phase2_enable;
  int error_cnt = 0;
  int checked = 0;
  int n;
  logic [31:0] seed;
  localparam int PG_CYC = 300; // Shortened boot delay, in cycles

  csq_sequencer #(.PG_DELAY_CYC(PG_CYC)) i_dut (.clk(clk), .rst(rst),
    .enable(enable),
    .deep_sleep_request(deep_sleep_request),
    .power_state_indicator(power_state_indicator),
    .voltage_code(voltage_code), .boot_code(boot_code),
    .feedback_sense_below_upper(below_upper),
    .feedback_sense_above_lower(above_lower),
    .thermistor_sense_in_low(thermistor_sense_in_low),
    .phase2_sense_positive_high(strap), .slew_at_target(slew_at_target),
    .clock_go_out_n(clock_go_out_n), .output_regulation_good_oe_n(good_oe_n),
    .output_regulation_good_o(good_o), .thermal_alarm_out_n_oe_n(hot_oe_n),
    .thermal_alarm_out_n_o(hot_o), .op_mode(op_mode),
    .target_code(target_code), .slew_divisor(slew_divisor),
    .slew_active(slew_active), .integrator_enable(integrator_enable),
    .phase2_enable(phase2_enable));

  csq_slew_model i_slew (.clk(clk), .rst(rst), .target_code(target_code),
    .slew_divisor(slew_divisor), .over(over), .under(under),
    .slew_at_target(slew_at_target), .below_upper(below_upper),
    .above_lower(above_lower));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Xorshift keeps the random draws repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected mode with the two-phase strap left open
  function automatic csq_mode_t exp_mode(input logic ds, input logic ps);
    if (ds) return ps ? CSQ_SKIP_LOW : CSQ_SKIP_VLOW;
    return ps ? CSQ_PWM_MAX_TWO : CSQ_PWM_ONE;
  endfunction

  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Bounded wait; an exhausted bound ends the run as a failure
  task automatic wait_lvl(ref logic s, input logic v, input int lim,
                          output int cnt);
    cnt = 0;
    while (s !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    if (s !== v) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  initial begin
    seed = 32'h7379a654;
    {rst, enable, deep_sleep_request, power_state_indicator} = 4'h8;
    {over, under, thermistor_sense_in_low, strap} = 4'h0;
    boot_code = 7'h00;
    voltage_code = 7'h00;
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // Values straight after reset
    chk(8'(clock_go_out_n), 8'h01);
    chk(8'(good_oe_n), 8'h00);
    chk(8'(hot_oe_n), 8'h01);
    chk(8'(op_mode), 8'(CSQ_PWM_MAX_TWO));
    chk(8'(slew_divisor), 8'(SLEW_FULL));
    chk(8'(integrator_enable), 8'h01);
    chk(8'(good_o), 8'h00);
    chk(8'(hot_o), 8'h00);
    // Startup: soft ramp to a random nonzero boot code
    boot_code = 7'(rnd() % 126) + 7'h01;
    voltage_code = boot_code ^ 7'h40;
    enable = 1'b1;
    wait_lvl(slew_active, 1'b1, 10, n);
    chk(8'(slew_divisor), 8'(SLEW_SOFT));
    chk(8'(op_mode), 8'(CSQ_PWM_MAX_TWO));
    chk(8'(target_code), 8'(boot_code));
    chk(8'(good_oe_n), 8'h00);
    wait_lvl(clock_go_out_n, 1'b0, 5000, n);
    wait_lvl(good_oe_n, 1'b1, PG_CYC + 10, n);
    chk(8'(n >= PG_CYC - 1), 8'h01);
    chk(8'(n <= PG_CYC + 3), 8'h01);
    // Boot to code transition
    chk(8'(slew_divisor), 8'(SLEW_FULL));
    chk(8'(op_mode), 8'(CSQ_PWM_MAX_TWO));
    chk(8'(target_code), 8'(voltage_code));
    chk(8'(clock_go_out_n), 8'h00);
    wait_lvl(slew_active, 1'b0, 3000, n);
    // Random code steps in run
    for (int i = 0; i < 6; i++) begin
      voltage_code = 7'(rnd());
      if (voltage_code == target_code) voltage_code = voltage_code ^ 7'h01;
      wait_lvl(slew_active, 1'b1, 10, n);
      chk(8'(target_code), 8'(voltage_code));
      chk(8'(clock_go_out_n), 8'h00);
      chk(8'(good_oe_n), 8'h01);
      wait_lvl(slew_active, 1'b0, 3000, n);
      step(2);
      chk(8'(clock_go_out_n), 8'(!good_oe_n));
      chk(8'(good_oe_n), 8'h01);
    end
    // Four modes with the strap open, then an upper-window fault in each
    for (int i = 0; i < 4; i++) begin
      {deep_sleep_request, power_state_indicator} = 2'(i);
      step(8);
      chk(8'(op_mode), 8'(exp_mode(i[1], i[0])));
      chk(8'(phase2_enable), 8'(i == 1));
      over = 1'b1;
      step(6);
      chk(8'(clock_go_out_n), 8'(!i[1]));
      chk(8'(good_oe_n), 8'(i[1]));
      chk(8'(integrator_enable), 8'(!i[1]));
      over = 1'b0;
      step(6);
    end
    // Lower-window fault in plain PWM
    {deep_sleep_request, power_state_indicator} = 2'(rnd() % 2);
    under = 1'b1;
    step(8);
    chk(8'(clock_go_out_n), 8'h01);
    chk(8'(good_oe_n), 8'h00);
    under = 1'b0;
    thermistor_sense_in_low = 1'b1;
    step(6);
    chk(8'(hot_oe_n), 8'h00);
    // Shutdown with the alarm still asserted
    enable = 1'b0;
    wait_lvl(slew_active, 1'b1, 10, n);
    chk(8'(slew_divisor), 8'(SLEW_SOFT));
    chk(8'(op_mode), 8'(CSQ_PWM_MAX_TWO));
    chk(8'(target_code), 8'(CODE_RESET));
    wait_lvl(slew_active, 1'b0, 4000, n);
    step(4);
    chk(8'(good_oe_n), 8'h00);
    chk(8'(hot_oe_n), 8'h01);
    // Second start with the one-phase strap fitted at maximum power
    strap = 1'b1;
    {deep_sleep_request, power_state_indicator} = 2'b01;
    enable = 1'b1;
    wait_lvl(slew_active, 1'b1, 10, n);
    chk(8'(good_oe_n), 8'h00);
    wait_lvl(good_oe_n, 1'b1, PG_CYC + 3000, n);
    wait_lvl(slew_active, 1'b0, 3000, n);
    step(4);
    chk(8'(op_mode), 8'(CSQ_PWM_MAX_ONE));
    chk(8'(phase2_enable), 8'h00);
    chk(8'(clock_go_out_n), 8'(!good_oe_n));
    wrap_up();
  end
endmodule
